// >>> dv/smw_host.sv
`timescale 1ns/1ns
module smw_host (
  input wire i_ref_clk,
  output reg o_start = 0,
  output reg o_hub = 0,
  output reg o_done = 0,
  output reg [31:0] o_addr = 0,
  output reg [3:0] o_id = 0
);
  // caller keeps the user window base size-aligned
  task txn(input h, input [31:0] a, input [3:0] d, input r);
    @(posedge i_ref_clk);
    o_start <= 1;
    o_hub <= h;
    o_addr <= a;
    o_id <= d;
    o_done <= r;
    @(posedge i_ref_clk);
    o_start <= 0;
    o_done <= 0;
    // address lines float after the cycle, so show junk
    o_addr <= ~a;
  endtask
endmodule

// >>> dv/smw_props.sv
`timescale 1ns/1ns
module smw_props (
  input wire i_ref_clk, i_rst_b, i_cfg_wr, i_txn_start, i_txn_hub, o_claim, o_claim_valid,
  input wire [7:0] i_cfg_idx, i_cfg_wdata, o_cfg_rdata, o_ctrl,
  input wire [3:0] i_txn_id
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  valid_pulse_a: assert property (i_txn_start |=> o_claim_valid)
    else $error("no valid");
  claim_hold_a: assert property (!i_txn_start |=> $stable(o_claim))
    else $error("claim moved");
  ctrl_write_a: assert property (i_cfg_wr && i_cfg_idx == 8'hf4 |-> ##2 o_ctrl == $past(i_cfg_wdata, 2))
    else $error("ctrl write");
  ctrl_read_a: assert property (i_cfg_idx == 8'hf4 && !i_cfg_wr |=> o_cfg_rdata == o_ctrl)
    else $error("ctrl read");
  unmapped_zero_a: assert property (i_cfg_idx < 8'hf4 |=> o_cfg_rdata == 8'h00)
    else $error("unmapped read");
  enable_norise_a: assert property ($rose(o_ctrl[3]) && $past(i_rst_b, 8) |-> $past(i_cfg_wr, 2))
    else $error("enable rose");
  claim_off_a: assert property (i_txn_start && (i_txn_hub ? !o_ctrl[3] : !o_ctrl[0] && !o_ctrl[2])
    |=> !o_claim)
    else $error("claim when off");
  id_mismatch_a: assert property (i_txn_start && i_txn_hub && i_txn_id != o_ctrl[7:4] |=> !o_claim)
    else $error("id ignored");
  cover property (i_txn_start ##1 o_claim);
  cover property (i_txn_start && i_txn_hub ##1 o_claim);
  cover property (i_cfg_wr && i_cfg_idx == 8'hf7);
endmodule
bind smw_decode smw_props props (.*);

// >>> dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  reg i_ref_clk = 0, i_rst_b = 0, i_ce = 1, i_boot_map_strap = 1, i_cfg_wr = 0, i_read_bios = 1;
  reg [7:0] i_cfg_idx = 0, i_cfg_wdata = 0;
  wire i_txn_start, i_txn_hub, i_read_done, o_claim, o_claim_valid;
  wire i_read_hub = i_txn_hub;
  wire [31:0] i_txn_addr;
  wire [3:0] i_txn_id;
  wire [7:0] o_cfg_rdata, o_ctrl;
  int fails = 0, tests_run = 0;
  reg [51:0] r;
  reg [51:0] rows [13] = '{52'h0100000f12341, 52'h0000000f12340, 52'h0100000e00000,
    52'h0300000effff1, 52'h0100ffe000001, 52'h0100ffdfffff0, 52'h04001235ffff1,
    52'h0400123600000, 52'h0400133400000, 52'h0300123400000, 52'h5851ffe010001,
    52'h5861ffe010000, 52'h5051ffe010000};
  smw_decode uut (.*);
  smw_host host (.i_ref_clk, .o_start(i_txn_start), .o_hub(i_txn_hub), .o_done(i_read_done),
    .o_addr(i_txn_addr), .o_id(i_txn_id));
  always #20 i_ref_clk = ~i_ref_clk;
  task chk(input [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, d);
    @(posedge i_ref_clk);
    i_cfg_wr <= 1;
    i_cfg_idx <= a;
    i_cfg_wdata <= d;
    @(posedge i_ref_clk);
    i_cfg_wr <= 0;
  endtask
  task rd(input [7:0] a, e);
    @(posedge i_ref_clk);
    i_cfg_idx <= a;
    @(posedge i_ref_clk);
    #1 chk(o_cfg_rdata, e);
  endtask
  task rst(input s);
    @(posedge i_ref_clk);
    i_boot_map_strap <= s;
    i_rst_b <= 0;
    repeat (12) @(posedge i_ref_clk);
    i_rst_b <= 1;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task finish_test;
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    finish_test;
  end
  initial begin
    rst(1);
    rd(8'hf4, 8'h09);
    rd(8'hf5, 8'h00);
    wr(8'hf5, 8'h12);
    wr(8'hf6, 8'h34);
    wr(8'hf7, 8'h01);
    rd(8'hf6, 8'h34);
    rd(8'h30, 8'h00);
    for (int k = 0; k < 13; k++) begin
      r = rows[k];
      wr(8'hf4, r[51:44]);
      host.txn(r[36], r[35:4], r[43:40], 1'b0);
      #1 chk(o_claim, r[0]);
    end
    rst(1);
    host.txn(1'b1, 32'hffe01000, 4'h0, 1'b1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_ctrl, 8'h08);
    wr(8'hf4, 8'h09);
    host.txn(1'b0, 32'h000f0000, 4'h0, 1'b1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_ctrl, 8'h09);
    rst(1);
    i_read_bios <= 0;
    host.txn(1'b0, 32'h000f0000, 4'h0, 1'b1);
    i_read_bios <= 1;
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_ctrl, 8'h09);
    host.txn(1'b0, 32'h000f0000, 4'h0, 1'b1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_ctrl, 8'h01);
    rst(0);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_ctrl, 8'h00);
    finish_test;
  end
endmodule

// >>> rtl/smw_consts.vh
// Functional notes
// - host reset loads control byte with 0x00; the third clock after release loads 0x00 or 0x09 chosen by boot strap.
// - control bit 0 set claims lpc memory cycles in bios lpc space.
// - both bios enable bits are set to 1 by the strap load in bios strap mode, else 0.
// - after reset in bios strap mode, bios enables follow the detected host boot protocol.
// - control bit 1 adds extended legacy bios range; resets to 0.
// - control bit 2 claims lpc memory cycles in user window; resets to 0.
// - control bit 3 claims hub transactions to bios hub space.
// - control bits 7-4 hold the hub select nibble matched against transaction id.
// - base high byte is compared with address bits 31-24.
// - base low byte gives base bits 23-16; bits 15-0 are zero.
// - both base bytes are read/write and reset to 0x00.
// - first bios read after the strap load and not in a config write cycle picks protocol and clears the other enable, once only.
// - lpc bios space is f0000-fffff, top 2m, and e0000-effff if extended.
// - hub accesses decode the id field only; no address bits are compared.
// - window size is 2^(size+16) bytes for size up to 5; 0 gives 64k, 5 and above give 2m.
`ifndef SMW_CONSTS_VH
`define SMW_CONSTS_VH
`define SMW_IDX_CTRL 8'hf4
`define SMW_IDX_BASE_HI 8'hf5
`define SMW_IDX_BASE_LO 8'hf6
`define SMW_IDX_SIZE 8'hf7
`define SMW_CTRL_RST_OFF 8'h00
`define SMW_CTRL_RST_BOOT 8'h09
`define SMW_BASE_RST 8'h00
`define SMW_SIZE_RST 8'h00
`define SMW_BIT_LPC_EN 0
`define SMW_BIT_EXT_EN 1
`define SMW_BIT_USER_EN 2
`define SMW_BIT_HUB_EN 3
`define SMW_SIZE_MAX 4'h5
`define SMW_LEG_F_PAGE 16'h000f
`define SMW_LEG_E_PAGE 16'h000e
`define SMW_TOP_2M 11'h7ff
`endif

// >>> rtl/smw_decode.v
`timescale 1ns/1ns
`include "smw_consts.vh"
module smw_decode (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_boot_map_strap,
  input wire i_cfg_wr,
  input wire [7:0] i_cfg_idx,
  input wire [7:0] i_cfg_wdata,
  output reg [7:0] o_cfg_rdata,
  input wire i_txn_start,
  input wire i_txn_hub,
  input wire [31:0] i_txn_addr,
  input wire [3:0] i_txn_id,
  input wire i_read_done,
  input wire i_read_hub,
  input wire i_read_bios,
  output reg o_claim,
  output reg o_claim_valid,
  output reg [7:0] o_ctrl
);
  reg strap_q;
  reg strap_taken;
  reg [1:0] strap_wait;
  reg detect_done;
  reg [7:0] ctrl;
  reg [7:0] base_hi;
  reg [7:0] base_lo;
  reg [3:0] size_sel;
  reg next_claim;
  reg [15:0] win_mask;

  smw_sync u_strap_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_d(i_boot_map_strap),
    .o_q(strap_q)
  );

  // mask of address bits 31-16 that take part in the window compare
  function [15:0] size_mask;
    input [3:0] sz;
    begin
      size_mask = 16'hffff << sz;
    end
  endfunction

  function lpc_bios_hit;
    input [31:0] a;
    input ext_en;
    begin
      lpc_bios_hit = (a[31:16] == `SMW_LEG_F_PAGE) ||
        (ext_en && (a[31:16] == `SMW_LEG_E_PAGE)) ||
        (a[31:21] == `SMW_TOP_2M);
    end
  endfunction

  always @* begin
    win_mask = size_mask((size_sel > `SMW_SIZE_MAX) ? `SMW_SIZE_MAX : size_sel);
    next_claim = 1'b0;
    if (i_txn_hub) begin
      // hub cycles carry only 21 address bits plus id; no address bits are looked at, only the id
      if (ctrl[`SMW_BIT_HUB_EN] && (i_txn_id == ctrl[7:4]))
        next_claim = 1'b1;
    end else begin
      if (ctrl[`SMW_BIT_LPC_EN] && lpc_bios_hit(i_txn_addr, ctrl[`SMW_BIT_EXT_EN]))
        next_claim = 1'b1;
      if (ctrl[`SMW_BIT_USER_EN] &&
          ((i_txn_addr[31:16] & win_mask) == ({base_hi, base_lo} & win_mask)))
        next_claim = 1'b1;
    end
  end

  // claim is sampled at transaction start so mid-cycle writes wait for the next one
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_claim <= 1'b0;
      o_claim_valid <= 1'b0;
    end else if (i_ce) begin
      o_claim_valid <= i_txn_start;
      if (i_txn_start)
        o_claim <= next_claim;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl <= `SMW_CTRL_RST_OFF;
      base_hi <= `SMW_BASE_RST;
      base_lo <= `SMW_BASE_RST;
      size_sel <= 4'h0;
      strap_taken <= 1'b0;
      strap_wait <= 2'h0;
      detect_done <= 1'b0;
    end else if (i_ce) begin
      if (strap_wait != 2'h2) begin
        // synchroniser sits in reset too, so wait until it carries the pin level
        strap_wait <= strap_wait + 2'h1;
      end else if (!strap_taken) begin
        strap_taken <= 1'b1;
        ctrl <= strap_q ? `SMW_CTRL_RST_BOOT : `SMW_CTRL_RST_OFF;
      end else if (i_cfg_wr) begin
        case (i_cfg_idx)
          `SMW_IDX_CTRL: ctrl <= i_cfg_wdata;
          `SMW_IDX_BASE_HI: base_hi <= i_cfg_wdata;
          `SMW_IDX_BASE_LO: base_lo <= i_cfg_wdata;
          `SMW_IDX_SIZE: size_sel <= i_cfg_wdata[3:0];
          default: ctrl <= ctrl;
        endcase
      end else if (i_read_done && i_read_bios && !detect_done) begin
        detect_done <= 1'b1;
        if (i_read_hub)
          ctrl[`SMW_BIT_LPC_EN] <= 1'b0;
        else
          ctrl[`SMW_BIT_HUB_EN] <= 1'b0;
      end
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_rdata <= 8'h00;
      o_ctrl <= 8'h00;
    end else if (i_ce) begin
      o_ctrl <= ctrl;
      case (i_cfg_idx)
        `SMW_IDX_CTRL: o_cfg_rdata <= ctrl;
        `SMW_IDX_BASE_HI: o_cfg_rdata <= base_hi;
        `SMW_IDX_BASE_LO: o_cfg_rdata <= base_lo;
        `SMW_IDX_SIZE: o_cfg_rdata <= {4'h0, size_sel};
        default: o_cfg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// >>> rtl/smw_sync.v
`timescale 1ns/1ns
module smw_sync (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_d,
  output reg o_q
);
  reg stage1;
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage1 <= 1'b0;
      o_q <= 1'b0;
    end else if (i_ce) begin
      stage1 <= i_d;
      o_q <= stage1;
    end
  end
endmodule
